//--- dv/tb_top.sv
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk;
   logic reset;
   logic [3:0] addr;
   logic [31:0] swData;
   logic wrStb;
   logic rdStb;
   logic [31:0] rdData;
   logic macValid;
   logic [7:0] macData;
   logic macLast;
   logic macReady = 1'b0;
   logic macStatValid = 1'b0;
   logic [2:0] statDly = 3'h0;
   // Result fields for the next packet, laid out as in the status word.
   logic [11:0] ms;
   logic [7:0] nextByte;
   logic [7:0] expQ [$];
   logic [7:0] gotQ [$];
   int nStat = 0;
   int nSeen = 0;
   int errors = 0;
   int checks = 0;
   int cyc = 0;
   int lastCnt = 0;
   logic skipA = 1'b0;
   txu_if lnk ();
   txu_device i_txu_device (.sys_clk(sys_clk), .reset(reset), .lnk(lnk.dev),
      .macValid(macValid), .macData(macData), .macLast(macLast), .macReady(macReady),
      .macStatValid(macStatValid), .macLossCarrier(ms[11]), .macNoCarrier(ms[10]),
      .macLateCol(ms[9]), .macExcCol(ms[8]), .macColCount(ms[6:3]),
      .macDeferCheck(ms[1]), .macExcDefer(ms[2]), .macDeferred(ms[0]));
   txu_host i_txu_host (.sys_clk(sys_clk), .reset(reset), .addr(addr), .wrData(swData),
      .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData), .lnk(lnk.host));
   txu_monitor #(.STAT_DEPTH(txu_pkg::STAT_DEPTH)) i_txu_monitor (.sys_clk(sys_clk),
      .reset(reset), .wrValid(lnk.wrValid), .wrData(lnk.wrData), .wrReady(lnk.wrReady),
      .stPop(lnk.stPop), .stData(lnk.stData), .stUsed(lnk.stUsed), .stAvail(lnk.stAvail),
      .status_discard_overrun_enable(lnk.status_discard_overrun_enable),
      .errClr(lnk.errClr), .transmit_error_flag(lnk.transmit_error_flag));
   initial begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end
   // The MAC stalls every other cycle and answers a few cycles after the last byte.
   always @(posedge sys_clk) begin
      macReady <= ~macReady;
      macStatValid <= (statDly == 3'h1);
      if (macValid && macReady) begin
         gotQ.push_back(macData);
         if (macLast) begin
            lastCnt = gotQ.size();
         end
      end
      if (macValid && macReady && macLast) begin
         statDly <= 3'h4;
      end else if (statDly != 3'h0) begin
         statDly <= statDly - 3'h1;
      end
      if (macStatValid) begin
         nStat++;
      end
      cyc++;
      if (cyc == 30000) begin
         errors++;
         end_of_test();
      end
   end
   task automatic end_of_test();
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         errors++;
         $display("BAD %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      addr <= a;
      swData <= d;
      wrStb <= 1'b1;
      @(posedge sys_clk);
      wrStb <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge sys_clk);
      addr <= a;
      rdStb <= 1'b1;
      @(posedge sys_clk);
      rdStb <= 1'b0;
      @(posedge sys_clk);
      d = rdData;
   endtask
   function automatic logic [31:0] st(input logic [15:0] tag);
      logic x;
      x = ms[2] & ms[1];
      return {tag, |ms[11:8] | x, 3'h0, ms[11:8], 1'b0, ms[6:3], x, 1'b0, ms[0]};
   endfunction
   // Filler bytes are a fixed marker value so that a leaked pad byte shows in the stream.
   task automatic sbuf(input logic firstSeg, input logic lastSeg, input int off, input int sz,
      input int al, input logic [15:0] tag, input int len);
      int ab;
      logic [31:0] w;
      ab = (al == 0) ? 4 : (al == 1) ? 16 : 32;
      // A first word already left pending by the caller stands for this buffer's own.
      if (skipA) begin
         skipA = 1'b0;
      end else begin
         wr(txu_pkg::REG_DATA, {6'h0, al[1:0], 2'h0, off[5:0], 2'h0, firstSeg, lastSeg, 1'b0,
            sz[10:0]});
      end
      wr(txu_pkg::REG_DATA, {tag, 5'h0, len[10:0]});
      for (int k = 0; k < (off + sz + ab - 1) / ab * ab; k++) begin
         w[8 * (k % 4) +: 8] = 8'hee;
         if (k >= off && k < off + sz) begin
            w[8 * (k % 4) +: 8] = nextByte;
            expQ.push_back(nextByte);
            nextByte++;
         end
         if (k % 4 == 3) begin
            wr(txu_pkg::REG_DATA, w);
         end
      end
   endtask
   task automatic pkt_done(input logic [15:0] tag, input logic pop);
      logic [31:0] s;
      int t;
      t = 0;
      while (nStat == nSeen && t < 500) begin
         @(posedge sys_clk);
         t++;
      end
      nSeen++;
      chk("statWait", 1, t < 500);
      repeat (3) @(posedge sys_clk);
      chk("count", expQ.size(), gotQ.size());
      chk("last", expQ.size(), lastCnt);
      lastCnt = 0;
      foreach (gotQ[k]) begin
         if (k < expQ.size()) begin
            chk("byte", expQ[k], gotQ[k]);
         end
      end
      expQ.delete();
      gotQ.delete();
      if (pop) begin
         rd(txu_pkg::REG_STATUS, s);
         chk("status", st(tag), s);
      end
   endtask
   task automatic t_lanes();
      for (int i = 0; i < 5; i++) begin
         sbuf(1, 1, (i == 4) ? 31 : i * 9, 1 + i * 7, i % 3, 16'h1000 + i[15:0], 1 + i * 7);
         pkt_done(16'h1000 + i[15:0], 1);
      end
   endtask
   task automatic t_frag();
      sbuf(1, 0, 3, 5, 1, 16'h2000, 10);
      sbuf(0, 0, 1, 4, 0, 16'h2000, 10);
      repeat (20) @(posedge sys_clk);
      chk("early", 0, gotQ.size());
      sbuf(0, 1, 6, 1, 2, 16'h2000, 10);
      pkt_done(16'h2000, 1);
   endtask
   task automatic t_status();
      logic [11:0] tbl [7];
      tbl = '{12'h800, 12'h401, 12'h228, 12'h178, 12'h007, 12'h005, 12'h000};
      for (int i = 0; i < 7; i++) begin
         ms <= tbl[i];
         sbuf(1, 1, 0, 4, 0, 16'h3000 + i[15:0], 4);
         pkt_done(16'h3000 + i[15:0], 1);
      end
      ms <= 12'h000;
   endtask
   task automatic t_err();
      logic [31:0] v;
      sbuf(1, 1, 0, 5, 0, 16'h4000, 9);
      pkt_done(16'h4000, 1);
      rd(txu_pkg::REG_INFO, v);
      chk("lenErr", 1, v[txu_pkg::INFO_ERR_BIT]);
      wr(txu_pkg::REG_INFO, 32'h100);
      rd(txu_pkg::REG_INFO, v);
      chk("errClr", 0, v[txu_pkg::INFO_ERR_BIT]);
      sbuf(1, 0, 0, 4, 0, 16'h4001, 8);
      sbuf(0, 1, 0, 4, 0, 16'h4002, 8);
      pkt_done(16'h4001, 1);
      rd(txu_pkg::REG_INFO, v);
      chk("cmdErr", 1, v[txu_pkg::INFO_ERR_BIT]);
      wr(txu_pkg::REG_INFO, 32'h100);
   endtask
   task automatic t_full();
      logic [31:0] v;
      for (int i = 0; i < 16; i++) begin
         sbuf(1, 1, 0, 4, 0, 16'h5000 + i[15:0], 4);
         pkt_done(16'h5000 + i[15:0], 0);
      end
      rd(txu_pkg::REG_INFO, v);
      chk("used", 16, v[4:0]);
      chk("avail", 1, v[txu_pkg::INFO_AVAIL_BIT]);
      sbuf(1, 1, 0, 4, 0, 16'h5010, 4);
      repeat (60) @(posedge sys_clk);
      chk("stalled", 0, gotQ.size());
      // The next packet's first word waits on the link until a status is taken and the held packet's status comes back from the MAC.
      skipA = 1'b1;
      wr(txu_pkg::REG_DATA, 32'h00003004);
      rd(txu_pkg::REG_INFO, v);
      chk("busy", 1, v[txu_pkg::INFO_BUSY_BIT]);
      rd(txu_pkg::REG_STATUS, v);
      chk("status", st(16'h5000), v);
      pkt_done(16'h5010, 0);
      wr(txu_pkg::REG_CONFIG, 32'h1);
      sbuf(1, 1, 0, 4, 0, 16'h5011, 4);
      pkt_done(16'h5011, 0);
      rd(txu_pkg::REG_INFO, v);
      chk("usedOvr", 0, v[4:0]);
      chk("ovrErr", 0, v[txu_pkg::INFO_ERR_BIT]);
      for (int i = 1; i < 17; i++) begin
         rd(txu_pkg::REG_STATUS, v);
         chk("drain", st(16'h5000 + i[15:0]), v);
      end
      wr(txu_pkg::REG_CONFIG, 32'h0);
   endtask
   initial begin
      reset = 1'b1;
      addr = 4'h0;
      swData = 32'h0;
      wrStb = 1'b0;
      rdStb = 1'b0;
      ms = 12'h000;
      nextByte = 8'h01;
      repeat (8) @(posedge sys_clk);
      reset <= 1'b0;
      t_lanes();
      t_frag();
      t_status();
      t_err();
      t_full();
      end_of_test();
   end
endmodule // tb_top
`default_nettype wire

//--- dv/txu_monitor.sv
`default_nettype none
module txu_monitor #(
   parameter int STAT_DEPTH = 16
) (
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic reset,
   // Link signals.
   input wire logic wrValid,
   input wire logic [31:0] wrData,
   input wire logic wrReady,
   input wire logic stPop,
   input wire logic [31:0] stData,
   input wire logic [4:0] stUsed,
   input wire logic stAvail,
   input wire logic status_discard_overrun_enable,
   input wire logic errClr,
   input wire logic transmit_error_flag
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);
   AST_WR_HOLD: assert property (wrValid && !wrReady |=> wrValid && $stable(wrData))
      else $error("offered word changed before it was taken");
   AST_WR_DROP: assert property (wrValid && wrReady |=> !wrValid)
      else $error("taken word still offered");
   AST_AVAIL: assert property (stUsed != 0 |-> stAvail)
      else $error("status held but not flagged available");
   AST_POP: assert property (stPop && stUsed != 0 |=> stUsed <= $past(stUsed))
      else $error("status count grew on a pop");
   AST_KEEP: assert property (stUsed != 0 && stUsed < STAT_DEPTH && !stPop
      |=> stUsed >= $past(stUsed))
      else $error("status lost without a pop");
   AST_STALL: assert property (stUsed == STAT_DEPTH && !status_discard_overrun_enable
      && !stPop |=> stUsed == STAT_DEPTH)
      else $error("full status store changed without a pop");
   AST_HOLD: assert property (stAvail && stUsed == 0 && !stPop |=> stUsed == 0)
      else $error("overrun count left zero without a pop");
   AST_NO_ERR: assert property ((status_discard_overrun_enable && !transmit_error_flag
      && stUsed == STAT_DEPTH) ##1 (stUsed == 0) |-> !transmit_error_flag [*2])
      else $error("overrun raised the error flag in discard mode");
   AST_STICKY: assert property (transmit_error_flag && !errClr |=> transmit_error_flag)
      else $error("error flag dropped without a clear");
   AST_HEAD: assert property (stAvail && !stPop |=> stAvail && $stable(stData))
      else $error("status head changed without a pop");
   COV_FULL: cover property (stUsed == STAT_DEPTH);
   COV_OVERRUN: cover property (stAvail && stUsed == 0);
   COV_ERR: cover property ($rose(transmit_error_flag));
endmodule // txu_monitor
`default_nettype wire

//--- hw/txu_device.sv
// How it works
// - Buffer is two command words, then data
// - Offset low bits pick first byte lane
// - Offset bits 5:2 skip whole words
// - Trailing unused bytes never reach MAC
// - End alignment 4, 16 or 32 stripped
// - Host pads buffer to chosen alignment
// - Host keeps middle buffers four bytes plus
// - Any byte start, end, first, last length
// - Host keeps packet within 2036 bytes
// - MAC sends only complete stored packets
// - Strip whole words, keep partial words
// - One status per packet; stall when full
// - Discard mode: keep sending, used reads zero after overrun
// - Discard mode overrun raises no error
// - Status high half returns packet tag
// - Bit 15 ORs the error bits
// - Bits 11, 10 report carrier problems
// - Bit 9 reports late collision
// - Bit 8 reports sixteen collisions abort
// - Bits 6:3 hold collision count
// - Bit 2 excessive deferral, bit 0 deferred
// - Keep first word always, second on first
// - Length mismatch sets transmit error
// - Differing second words set transmit error
`default_nettype none
module txu_device #(
   parameter int MAC_BYTES = txu_pkg::MAC_BYTES,
   parameter int STAT_DEPTH = txu_pkg::STAT_DEPTH
) (
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic reset,
   // Link to the host.
   txu_if.dev lnk,
   // Byte stream to the MAC.
   output logic macValid,
   output logic [7:0] macData,
   output logic macLast,
   input wire logic macReady,
   // Per-packet result from the MAC.
   input wire logic macStatValid,
   input wire logic macLossCarrier,
   input wire logic macNoCarrier,
   input wire logic macLateCol,
   input wire logic macExcCol,
   input wire logic [3:0] macColCount,
   input wire logic macDeferCheck,
   input wire logic macExcDefer,
   input wire logic macDeferred
);
   localparam int PW = $clog2(MAC_BYTES + 1);
   localparam int SW = $clog2(STAT_DEPTH);
   localparam int CW = $clog2(STAT_DEPTH + 1);

   typedef struct packed {
      txu_pkg::txu_rx_t rx;
      txu_pkg::txu_tx_t tx;
      logic [5:0] off;
      logic [1:0] align;
      logic [10:0] size;
      logic firstSeg;
      logic lastSeg;
      logic [31:0] cmdB;
      logic [9:0] idx;
      logic [9:0] dataEnd;
      logic [9:0] totWords;
      logic [10:0] remBytes;
      logic [PW-1:0] wrPtr;
      logic [PW-1:0] rdPtr;
      logic macValid;
      logic [7:0] macData;
      logic macLast;
      logic [STAT_DEPTH-1:0][31:0] stMem;
      logic [SW-1:0] stWp;
      logic [SW-1:0] stRp;
      logic [CW-1:0] stCnt;
      logic overrunHold;
      logic txErr;
      logic wrReady;
   } txu_dev_st_t;

   txu_dev_st_t st_q;
   txu_dev_st_t st_d;
   logic [7:0] macMem [0:MAC_BYTES-1];
   logic [3:0] laneWe;
   logic [1:0] laneFirst;

   // Rounds a byte count up to the alignment boundary and returns words.
   function automatic logic [9:0] padWords(input logic [11:0] bytes, input logic [1:0] al);
      logic [11:0] mask;
      mask = (al == txu_pkg::ALIGN_32) ? 12'h01f : (al == txu_pkg::ALIGN_16) ? 12'h00f : 12'h003;
      padWords = 10'((bytes + mask) >> 2 & ~(mask >> 2));
   endfunction

   always_comb begin
      logic accept;
      logic bodyDone;
      logic [31:0] w;
      logic [11:0] tot;
      logic [2:0] n;
      logic [3:0] errEv;
      logic [31:0] sw;
      logic pop;
      logic push;
      accept = 1'b0;
      bodyDone = 1'b0;
      w = lnk.wrData;
      tot = 12'h000;
      n = 3'h0;
      errEv = 4'h0;
      sw = 32'h0;
      pop = 1'b0;
      push = 1'b0;
      laneWe = 4'h0;
      laneFirst = 2'h0;
      st_d = st_q;
      accept = lnk.wrValid && st_q.wrReady;
      case (st_q.rx)
         txu_pkg::RX_CMDA: begin
            if (accept) begin
               st_d.off = w[txu_pkg::CMDA_OFF_LSB +: 6];
               st_d.align = w[txu_pkg::CMDA_ALIGN_LSB +: 2];
               st_d.size = w[txu_pkg::CMDA_SIZE_LSB +: 11];
               st_d.firstSeg = w[txu_pkg::CMDA_FIRST_BIT];
               st_d.lastSeg = w[txu_pkg::CMDA_LAST_BIT];
               st_d.rx = txu_pkg::RX_CMDB;
            end
         end
         txu_pkg::RX_CMDB: begin
            if (accept) begin
               if (st_q.firstSeg) begin
                  st_d.cmdB = w;
                  st_d.wrPtr = '0;
               end else if (w != st_q.cmdB) begin
                  errEv[0] = 1'b1;
               end
               tot = 12'(st_q.off) + 12'(st_q.size);
               st_d.idx = 10'h000;
               st_d.dataEnd = 10'((tot + 12'h003) >> 2);
               st_d.totWords = padWords(tot, st_q.align);
               st_d.remBytes = st_q.size;
               st_d.rx = txu_pkg::RX_BODY;
               bodyDone = (padWords(tot, st_q.align) == 10'h000);
            end
         end
         txu_pkg::RX_BODY: begin
            if (accept) begin
               st_d.idx = st_q.idx + 10'h001;
               // Skipped offset words and whole filler words are dropped here.
               if (st_q.idx >= 10'(st_q.off[5:2]) && st_q.idx < st_q.dataEnd) begin
                  laneFirst = (st_q.idx == 10'(st_q.off[5:2])) ? st_q.off[1:0] : 2'h0;
                  n = (st_q.remBytes < 11'(3'h4 - 3'(laneFirst))) ?
                      3'(st_q.remBytes) : 3'(3'h4 - 3'(laneFirst));
                  for (int i = 0; i < 4; i++) begin
                     laneWe[i] = (i >= int'(laneFirst)) && (i < int'(laneFirst) + int'(n));
                  end
                  st_d.remBytes = st_q.remBytes - 11'(n);
                  st_d.wrPtr = st_q.wrPtr + PW'(n);
               end
               bodyDone = (st_q.idx + 10'h001 == st_q.totWords);
            end
         end
         txu_pkg::RX_HOLD: begin
         end
         default: st_d.rx = txu_pkg::RX_CMDA;
      endcase
      if (bodyDone) begin
         st_d.rx = st_q.lastSeg ? txu_pkg::RX_HOLD : txu_pkg::RX_CMDA;
         if (st_q.lastSeg && st_d.wrPtr != PW'(st_d.cmdB[txu_pkg::CMDB_LEN_LSB +: 11])) begin
            errEv[1] = 1'b1;
         end
      end
      // Only one packet is held at a time, so the link stalls until the MAC returns its status.
      st_d.wrReady = (st_d.rx != txu_pkg::RX_HOLD);

      pop = lnk.stPop && (st_q.stCnt != '0);
      case (st_q.tx)
         txu_pkg::TX_IDLE: begin
            st_d.rdPtr = '0;
            if (st_q.rx == txu_pkg::RX_HOLD &&
                (st_q.stCnt != CW'(STAT_DEPTH) || lnk.status_discard_overrun_enable)) begin
               st_d.tx = txu_pkg::TX_SEND;
            end
         end
         txu_pkg::TX_SEND: begin
            if (!st_q.macValid || macReady) begin
               if (st_q.rdPtr < st_q.wrPtr) begin
                  st_d.macValid = 1'b1;
                  st_d.macData = macMem[st_q.rdPtr[PW-2:0]];
                  st_d.macLast = (st_q.rdPtr + PW'(1) == st_q.wrPtr);
                  st_d.rdPtr = st_q.rdPtr + PW'(1);
               end else begin
                  st_d.macValid = 1'b0;
                  st_d.macLast = 1'b0;
                  st_d.tx = txu_pkg::TX_STAT;
               end
            end
         end
         txu_pkg::TX_STAT: begin
            if (macStatValid) begin
               sw[txu_pkg::ST_TAG_LSB +: 16] = st_q.cmdB[txu_pkg::CMDB_TAG_LSB +: 16];
               sw[txu_pkg::ST_LOSS_CARRIER_BIT] = macLossCarrier;
               sw[txu_pkg::ST_NO_CARRIER_BIT] = macNoCarrier;
               sw[txu_pkg::ST_LATE_COL_BIT] = macLateCol;
               sw[txu_pkg::ST_EXC_COL_BIT] = macExcCol;
               sw[txu_pkg::ST_COL_CNT_LSB +: 4] = macColCount;
               sw[txu_pkg::ST_EXC_DEFER_BIT] = macDeferCheck && macExcDefer;
               sw[txu_pkg::ST_DEFERRED_BIT] = macDeferred;
               sw[txu_pkg::ST_ERR_SUM_BIT] = sw[11] | sw[10] | sw[9] | sw[8] |
                  sw[2] | sw[1];
               // A pop in the same cycle frees a slot, so this status is still stored then.
               if (!pop && (st_q.overrunHold || st_q.stCnt == CW'(STAT_DEPTH))) begin
                  st_d.overrunHold = 1'b1;
                  errEv[2] = !lnk.status_discard_overrun_enable;
               end else begin
                  push = 1'b1;
               end
               st_d.tx = txu_pkg::TX_IDLE;
               st_d.rx = txu_pkg::RX_CMDA;
               st_d.wrReady = 1'b1;
            end
         end
         default: st_d.tx = txu_pkg::TX_IDLE;
      endcase

      if (push) begin
         st_d.stMem[st_q.stWp] = sw;
         st_d.stWp = st_q.stWp + SW'(1);
      end
      if (pop) begin
         st_d.stRp = st_q.stRp + SW'(1);
         st_d.overrunHold = 1'b0;
      end
      st_d.stCnt = st_q.stCnt + CW'(push) - CW'(pop);
      // A new error in the clearing cycle survives the clear.
      st_d.txErr = (st_q.txErr && !lnk.errClr) || (errEv != 4'h0);
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         st_q <= '0;
         st_q.rx <= txu_pkg::RX_CMDA;
         st_q.tx <= txu_pkg::TX_IDLE;
         st_q.wrReady <= 1'b1;
      end else begin
         st_q <= st_d;
      end
   end

   // Byte store for one whole packet; kept outside the state record for size.
   always_ff @(posedge sys_clk) begin
      for (int i = 0; i < 4; i++) begin
         if (laneWe[i]) begin
            macMem[(st_q.wrPtr + PW'(i) - PW'(laneFirst)) % MAC_BYTES] <=
               lnk.wrData[8*i +: 8];
         end
      end
   end

   assign lnk.wrReady = st_q.wrReady;
   assign lnk.stData = st_q.stMem[st_q.stRp];
   assign lnk.stUsed = 5'(st_q.overrunHold ? '0 : st_q.stCnt);
   assign lnk.stAvail = (st_q.stCnt != '0);
   assign lnk.transmit_error_flag = st_q.txErr;
   assign macValid = st_q.macValid;
   assign macData = st_q.macData;
   assign macLast = st_q.macLast;
endmodule // txu_device
`default_nettype wire

//--- hw/txu_host.sv
`default_nettype none
module txu_host (
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic reset,
   // Software command port.
   input wire logic [3:0] addr,
   input wire logic [31:0] wrData,
   input wire logic wrStb,
   input wire logic rdStb,
   output logic [31:0] rdData,
   // Link to the device.
   txu_if.host lnk
);
   typedef struct packed {
      logic wrValid;
      logic [31:0] wrWord;
      logic stPop;
      logic discard;
      logic errClr;
      logic [31:0] rdData;
   } txu_host_st_t;

   txu_host_st_t st_q;
   txu_host_st_t st_d;

   always_comb begin
      st_d = st_q;
      st_d.stPop = 1'b0;
      st_d.errClr = 1'b0;
      st_d.rdData = 32'h0;
      if (st_q.wrValid && lnk.wrReady) begin
         st_d.wrValid = 1'b0;
      end
      if (wrStb) begin
         case (addr)
            // A word written while the previous one is pending and not taken that cycle is dropped; poll busy.
            txu_pkg::REG_DATA: begin
               if (!st_q.wrValid || lnk.wrReady) begin
                  st_d.wrValid = 1'b1;
                  st_d.wrWord = wrData;
               end
            end
            txu_pkg::REG_CONFIG: st_d.discard = wrData[txu_pkg::CFG_DISCARD_BIT];
            txu_pkg::REG_INFO: st_d.errClr = wrData[txu_pkg::INFO_ERR_BIT];
            default: begin
            end
         endcase
      end
      if (rdStb) begin
         case (addr)
            txu_pkg::REG_STATUS: begin
               st_d.rdData = lnk.stData;
               st_d.stPop = lnk.stAvail;
            end
            txu_pkg::REG_CONFIG: st_d.rdData[txu_pkg::CFG_DISCARD_BIT] = st_q.discard;
            txu_pkg::REG_INFO: begin
               st_d.rdData[4:0] = lnk.stUsed;
               st_d.rdData[txu_pkg::INFO_ERR_BIT] = lnk.transmit_error_flag;
               st_d.rdData[txu_pkg::INFO_BUSY_BIT] = st_q.wrValid;
               st_d.rdData[txu_pkg::INFO_AVAIL_BIT] = lnk.stAvail;
            end
            default: st_d.rdData = 32'h0;
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign lnk.wrValid = st_q.wrValid;
   assign lnk.wrData = st_q.wrWord;
   assign lnk.stPop = st_q.stPop;
   assign lnk.status_discard_overrun_enable = st_q.discard;
   assign lnk.errClr = st_q.errClr;
   assign rdData = st_q.rdData;
endmodule // txu_host
`default_nettype wire

//--- hw/txu_if.sv
`default_nettype none
interface txu_if;
   logic wrValid;
   logic [31:0] wrData;
   logic wrReady;
   logic stPop;
   logic [31:0] stData;
   logic [4:0] stUsed;
   logic stAvail;
   logic status_discard_overrun_enable;
   logic errClr;
   logic transmit_error_flag;
   modport dev (input wrValid, wrData, stPop, status_discard_overrun_enable, errClr,
      output wrReady, stData, stUsed, stAvail, transmit_error_flag);
   modport host (output wrValid, wrData, stPop, status_discard_overrun_enable, errClr,
      input wrReady, stData, stUsed, stAvail, transmit_error_flag);
endinterface
`default_nettype wire

//--- hw/txu_pkg.sv
`default_nettype none
package txu_pkg;
   // First command word fields.
   localparam int CMDA_SIZE_LSB = 0;
   localparam int CMDA_SIZE_W = 11;
   localparam int CMDA_LAST_BIT = 12;
   localparam int CMDA_FIRST_BIT = 13;
   localparam int CMDA_OFF_LSB = 16;
   localparam int CMDA_OFF_W = 6;
   localparam int CMDA_ALIGN_LSB = 24;
   localparam logic [1:0] ALIGN_4 = 2'h0;
   localparam logic [1:0] ALIGN_16 = 2'h1;
   localparam logic [1:0] ALIGN_32 = 2'h2;
   // Second command word fields.
   localparam int CMDB_LEN_LSB = 0;
   localparam int CMDB_TAG_LSB = 16;
   // Status word bit positions.
   localparam int ST_TAG_LSB = 16;
   localparam int ST_ERR_SUM_BIT = 15;
   localparam int ST_LOSS_CARRIER_BIT = 11;
   localparam int ST_NO_CARRIER_BIT = 10;
   localparam int ST_LATE_COL_BIT = 9;
   localparam int ST_EXC_COL_BIT = 8;
   localparam int ST_COL_CNT_LSB = 3;
   localparam int ST_EXC_DEFER_BIT = 2;
   localparam int ST_DEFERRED_BIT = 0;
   // Storage sizes.
   localparam int MAC_BYTES = 2048;
   localparam int STAT_DEPTH = 16;
   // Host command port register offsets.
   localparam logic [3:0] REG_DATA = 4'h0;
   localparam logic [3:0] REG_STATUS = 4'h4;
   localparam logic [3:0] REG_CONFIG = 4'h8;
   localparam logic [3:0] REG_INFO = 4'hc;
   localparam int CFG_DISCARD_BIT = 0;
   localparam int INFO_ERR_BIT = 8;
   localparam int INFO_BUSY_BIT = 9;
   localparam int INFO_AVAIL_BIT = 10;
   typedef enum logic [4:0] {
      RX_CMDA = 5'h01,
      RX_CMDB = 5'h02,
      RX_BODY = 5'h04,
      RX_HOLD = 5'h08,
      RX_SPARE = 5'h10
   } txu_rx_t;
   typedef enum logic [2:0] {
      TX_IDLE = 3'h1,
      TX_SEND = 3'h2,
      TX_STAT = 3'h4
   } txu_tx_t;
endpackage
`default_nettype wire
